// >>> hw/ir_remote_interrupt_control.sv
// Functional notes
// - falling input edge sets fall flag
// - rising input edge sets rise flag
// - counter underflow sets underflow flag
// - write one clears flag, zero ignored
// - three read/write enable bits, low bits
// - flags set regardless of enable, readable
// - enabled flag raises request same cycle
// - disabled cause never raises request
// - reserved bits read as zero
// - reset clears all flags and enables
// - length counter stops at zero, underflows
// - edge causes only in receive direction
`timescale 1ns/1ps
`default_nettype none
module ir_remote_interrupt_control
  import ir_irq_pkg::*;
#(
  parameter int AW = 18 // axi address width
)
(
  input  wire logic          mclk,         // system clock, 100 MHz
  input  wire logic          rst,          // sync reset, active high
  // axi4-lite slave
  input  wire logic [AW-1:0] s_awaddr,     // write address
  input  wire logic          s_awvalid,    // write address valid
  output logic               s_awready,    // write address ready
  input  wire logic [31:0]   s_wdata,      // write data
  input  wire logic [3:0]    s_wstrb,      // write byte strobes
  input  wire logic          s_wvalid,     // write data valid
  output logic               s_wready,     // write data ready
  output logic [1:0]         s_bresp,      // write response
  output logic               s_bvalid,     // write response valid
  input  wire logic          s_bready,     // write response ready
  input  wire logic [AW-1:0] s_araddr,     // read address
  input  wire logic          s_arvalid,    // read address valid
  output logic               s_arready,    // read address ready
  output logic [31:0]        s_rdata,      // read data
  output logic [1:0]         s_rresp,      // read response
  output logic               s_rvalid,     // read data valid
  input  wire logic          s_rready,     // read data ready
  // unit side
  input  wire logic          data_in,      // data pulse input, synchronous
  input  wire logic          len_tick,     // length counter clock enable pulse
  output logic               irq_request   // level request to irq controller
);
  // write channel state
  logic          aw_hold_ff;   // address captured
  logic [AW-1:0] aw_addr_ff;   // captured write address
  logic          w_hold_ff;    // data captured
  logic [31:0]   w_data_ff;    // captured write data
  logic [3:0]    w_strb_ff;    // captured strobes
  logic          bvalid_ff;    // response pending
  logic [1:0]    bresp_ff;     // response code
  // read channel state
  logic          rvalid_ff;    // read data pending
  logic [31:0]   rdata_ff;     // read data
  logic [1:0]    rresp_ff;     // read response code
  // register state
  cause_t        flag_ff;      // sticky cause flags
  cause_t        en_ff;        // enable bits
  logic          dir_rx_ff;    // direction: 1 receive
  // events and strobes
  cause_t        evt;          // cause pulses this cycle
  cause_t        clr;          // write-one-to-clear pulses
  logic          wr_go;        // write happens this cycle
  logic          wr_ctrl;      // write hits irq control
  logic          wr_cfg;       // write hits config
  logic          ar_go;        // read accepted this cycle
  logic [7:0]    len_count;    // current length count
  logic [31:0]   ctrl_view;    // read image of irq control
  logic [31:0]   cfg_view;     // read image of config

  // accept each channel once, in any order; stall while a response waits
  assign s_awready = !aw_hold_ff && !bvalid_ff;
  assign s_wready  = !w_hold_ff && !bvalid_ff;
  assign wr_go     = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign wr_ctrl   = wr_go && aw_addr_ff[AW-1:2] == IRQ_CTRL_ADDR[AW-1:2];
  assign wr_cfg    = wr_go && aw_addr_ff[AW-1:2] == UNIT_CFG_ADDR[AW-1:2];

  // write address capture
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= '0;
    end
    else if (s_awvalid && s_awready)
    begin
      aw_hold_ff <= 1'b1;
      aw_addr_ff <= s_awaddr;
    end
    else if (wr_go)
      aw_hold_ff <= 1'b0;
  end

  // write data capture
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      w_hold_ff <= 1'b0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
    end
    else if (s_wvalid && s_wready)
    begin
      w_hold_ff <= 1'b1;
      w_data_ff <= s_wdata;
      w_strb_ff <= s_wstrb;
    end
    else if (wr_go)
      w_hold_ff <= 1'b0;
  end

  // write response; unmapped addresses answer slverr and change nothing
  // readies stay low while a response waits, so a second write cannot overtake it
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (wr_ctrl || wr_cfg) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_bready)
      bvalid_ff <= 1'b0;
  end

  assign s_bvalid = bvalid_ff;
  assign s_bresp  = bresp_ff;

  // clear pulses come from byte lane 1 of a control write
  assign clr.ufl  = wr_ctrl && w_strb_ff[1] && w_data_ff[UFL_FLG_BIT];
  assign clr.rise = wr_ctrl && w_strb_ff[1] && w_data_ff[RISE_FLG_BIT];
  assign clr.fall = wr_ctrl && w_strb_ff[1] && w_data_ff[FALL_FLG_BIT];

  // enable bits live in byte lane 0
  always_ff @(posedge mclk)
  begin
    if (rst)
      en_ff <= EN_RST;
    else if (wr_ctrl && w_strb_ff[0])
    begin
      en_ff.ufl  <= w_data_ff[UFL_EN_BIT];
      en_ff.rise <= w_data_ff[RISE_EN_BIT];
      en_ff.fall <= w_data_ff[FALL_EN_BIT];
    end
  end

  // sticky flags: an event the same cycle as its clear survives
  // trade-off: software must re-read after a clear, a racing edge keeps the flag
  always_ff @(posedge mclk)
  begin
    if (rst)
      flag_ff <= FLAG_RST;
    else
      flag_ff <= evt | (flag_ff & ~clr);
  end

  // direction select, in our config register
  always_ff @(posedge mclk)
  begin
    if (rst)
      dir_rx_ff <= 1'b0;
    else if (wr_cfg && w_strb_ff[0])
      dir_rx_ff <= w_data_ff[DIR_BIT];
  end

  // edge causes from the data pulse input
  // the pin already lives in this clock domain, so no synchroniser stages here
  edge_detect u_edge (
    .mclk     (mclk),
    .rst      (rst),
    .arm      (dir_rx_ff),
    .din      (data_in),
    .rise_evt (evt.rise),
    .fall_evt (evt.fall)
  );

  // length counter, loaded from config byte lane 1
  // loading zero gives no underflow: the pulse needs a step down from one
  len_counter #(
    .W (LEN_BITS)
  ) u_len (
    .mclk     (mclk),
    .rst      (rst),
    .tick     (len_tick),
    .load     (wr_cfg && w_strb_ff[1]),
    .load_val (w_data_ff[LEN_LSB +: LEN_BITS]),
    .count    (len_count),
    .ufl_evt  (evt.ufl)
  );

  // request follows the flags combinationally, so it rises with the flag
  // a flop here would lag the flag by one cycle and miss the same-cycle rule
  assign irq_request = |(flag_ff & en_ff);

  // read images; every unnamed bit is zero
  always_comb
  begin
    ctrl_view               = '0;
    ctrl_view[UFL_EN_BIT]   = en_ff.ufl;
    ctrl_view[RISE_EN_BIT]  = en_ff.rise;
    ctrl_view[FALL_EN_BIT]  = en_ff.fall;
    ctrl_view[UFL_FLG_BIT]  = flag_ff.ufl;
    ctrl_view[RISE_FLG_BIT] = flag_ff.rise;
    ctrl_view[FALL_FLG_BIT] = flag_ff.fall;
    cfg_view                = '0;
    cfg_view[DIR_BIT]       = dir_rx_ff;
    cfg_view[LEN_LSB +: LEN_BITS] = len_count;
  end

  // read path: one request at a time, answered the cycle after acceptance
  // the image is taken at acceptance; an edge landing later shows on the next read
  assign s_arready = !rvalid_ff;
  assign ar_go     = s_arvalid && s_arready;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= RESP_OKAY;
    end
    else if (ar_go)
    begin
      rvalid_ff <= 1'b1;
      if (s_araddr[AW-1:2] == IRQ_CTRL_ADDR[AW-1:2])
      begin
        rdata_ff <= ctrl_view;
        rresp_ff <= RESP_OKAY;
      end
      else if (s_araddr[AW-1:2] == UNIT_CFG_ADDR[AW-1:2])
      begin
        rdata_ff <= cfg_view;
        rresp_ff <= RESP_OKAY;
      end
      else
      begin
        rdata_ff <= '0;
        rresp_ff <= RESP_SLVERR;
      end
    end
    else if (s_rready)
      rvalid_ff <= 1'b0;
  end

  assign s_rvalid = rvalid_ff;
  assign s_rdata  = rdata_ff;
  assign s_rresp  = rresp_ff;

  // assertions

  // multi-step behaviours are spelled out as named sequences first
  // last tick of a length count, with no load fighting it
  sequence s_last_tick;
    len_count == 8'h01 && len_tick && !(wr_cfg && w_strb_ff[1]);
  endsequence

  // underflow pulse, then the sticky flag one edge later
  sequence s_ufl_latched;
    evt.ufl ##1 flag_ff.ufl;
  endsequence

  // enabled falling edge while software leaves the enables alone
  sequence s_fall_caught;
    evt.fall && en_ff.fall && !(wr_ctrl && w_strb_ff[0]);
  endsequence

  // fall flag up and the request already showing it
  sequence s_request_up;
    flag_ff.fall && irq_request;
  endsequence

  // control write on lane 1 with a zero in the fall flag bit
  sequence s_fall_zero_write;
    wr_ctrl && w_strb_ff[1] && !w_data_ff[FALL_FLG_BIT] && flag_ff.fall;
  endsequence

  // rise flag wiped by software with no new edge arriving
  sequence s_rise_wipe;
    clr.rise && !evt.rise;
  endsequence

  a_flag_set_event: assert property (@(posedge mclk) disable iff (rst)
    evt.fall |=> flag_ff.fall)
    else $error("fall flag not set after edge");
  a_rise_set_event: assert property (@(posedge mclk) disable iff (rst)
    evt.rise |=> flag_ff.rise)
    else $error("rise flag not set after edge");
  a_ufl_set_event: assert property (@(posedge mclk) disable iff (rst)
    evt.ufl |=> flag_ff.ufl)
    else $error("underflow flag not set");
  a_clear_works: assert property (@(posedge mclk) disable iff (rst)
    (clr.ufl && !evt.ufl) |=> !flag_ff.ufl)
    else $error("write one did not clear flag");
  a_flag_hold: assert property (@(posedge mclk) disable iff (rst)
    (flag_ff.rise && !clr.rise) |=> flag_ff.rise)
    else $error("flag lost without clear");
  a_irq_enabled: assert property (@(posedge mclk) disable iff (rst)
    (flag_ff.fall && en_ff.fall) |-> irq_request)
    else $error("enabled flag without request");
  a_irq_masked: assert property (@(posedge mclk) disable iff (rst)
    (!(flag_ff.ufl && en_ff.ufl) && !(flag_ff.rise && en_ff.rise)
     && !(flag_ff.fall && en_ff.fall)) |-> !irq_request)
    else $error("request without enabled flag");
  a_set_wins: assert property (@(posedge mclk) disable iff (rst)
    (evt.rise && clr.rise) |=> flag_ff.rise)
    else $error("event lost to clear");
  a_reserved_zero: assert property (@(posedge mclk) disable iff (rst)
    ctrl_view[31:11] == '0 && ctrl_view[7:3] == '0)
    else $error("reserved bits not zero");
  a_edge_rx_only: assert property (@(posedge mclk) disable iff (rst)
    !dir_rx_ff |-> !(evt.rise || evt.fall))
    else $error("edge cause while transmitting");
  a_cnt_stops: assert property (@(posedge mclk) disable iff (rst)
    (len_count == 8'h00 && !(wr_cfg && w_strb_ff[1])) |=> len_count == 8'h00)
    else $error("counter moved below zero");
  a_reset_clear: assert property (@(posedge mclk)
    rst |=> (flag_ff == FLAG_RST && en_ff == EN_RST))
    else $error("reset did not clear control");
  a_ufl_chain: assert property (@(posedge mclk) disable iff (rst)
    s_last_tick |=> s_ufl_latched)
    else $error("last tick did not latch underflow");
  a_count_lands: assert property (@(posedge mclk) disable iff (rst)
    s_last_tick |=> len_count == 8'h00)
    else $error("last tick did not reach zero");
  a_fall_request: assert property (@(posedge mclk) disable iff (rst)
    s_fall_caught |=> s_request_up)
    else $error("enabled fall edge gave no request");
  a_zero_ignored: assert property (@(posedge mclk) disable iff (rst)
    s_fall_zero_write |=> flag_ff.fall)
    else $error("zero write cleared fall flag");
  a_rise_clears: assert property (@(posedge mclk) disable iff (rst)
    s_rise_wipe |=> !flag_ff.rise)
    else $error("write one left rise flag set");
endmodule : ir_remote_interrupt_control
`default_nettype wire

// >>> hw/ir_irq_pkg.sv
package ir_irq_pkg;
  // register index as printed (not a multiple of four), byte address is index * 4
  localparam logic [15:0] IRQ_CTRL_INDEX = 16'h5346;
  localparam logic [17:0] IRQ_CTRL_ADDR  = {IRQ_CTRL_INDEX, 2'b00};
  // private configuration / status register of ours
  localparam logic [17:0] UNIT_CFG_ADDR  = 18'h0_0100;
  // bit positions inside the irq control register
  localparam int UFL_EN_BIT   = 0;
  localparam int RISE_EN_BIT  = 1;
  localparam int FALL_EN_BIT  = 2;
  localparam int UFL_FLG_BIT  = 8;
  localparam int RISE_FLG_BIT = 9;
  localparam int FALL_FLG_BIT = 10;
  // configuration register bit positions
  localparam int DIR_BIT      = 0;
  localparam int LEN_LSB      = 8;
  localparam int LEN_BITS     = 8;
  // reset values
  localparam logic [2:0]  FLAG_RST = 3'h0;
  localparam logic [2:0]  EN_RST   = 3'h0;
  localparam logic [7:0]  LEN_RST  = 8'h00;
  // axi responses
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // one bit per cause: underflow, rise, fall
  typedef struct packed {
    logic fall;
    logic rise;
    logic ufl;
  } cause_t;
endpackage : ir_irq_pkg

// >>> hw/edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
module edge_detect
  import ir_irq_pkg::*;
(
  input  wire logic mclk,     // system clock
  input  wire logic rst,      // sync reset, active high
  input  wire logic arm,      // receive direction selected
  input  wire logic din,      // data pulse input, synchronous
  output logic      rise_evt, // one-cycle rise pulse
  output logic      fall_evt  // one-cycle fall pulse
);
  logic last_ff; // previous sample of din

  // track the input even when not armed, so arming gives no false edge
  always_ff @(posedge mclk)
  begin
    if (rst)
      last_ff <= 1'b0;
    else
      last_ff <= din;
  end

  // edges only count in receive direction
  assign rise_evt = arm & din & ~last_ff;
  assign fall_evt = arm & ~din & last_ff;
endmodule : edge_detect
`default_nettype wire

// >>> hw/len_counter.sv
`timescale 1ns/1ps
`default_nettype none
module len_counter
  import ir_irq_pkg::*;
#(
  parameter int W = LEN_BITS // counter width
)
(
  input  wire logic         mclk,    // system clock
  input  wire logic         rst,     // sync reset, active high
  input  wire logic         tick,    // count enable pulse
  input  wire logic         load,    // software load strobe
  input  wire logic [W-1:0] load_val,// value to load
  output logic [W-1:0]      count,   // current count
  output logic              ufl_evt  // one-cycle pulse on reaching zero
);
  logic [W-1:0] cnt_ff; // down counter
  logic         ufl_ff; // registered underflow pulse

  // counts down, stops at zero; load wins over counting
  always_ff @(posedge mclk)
  begin
    if (rst)
      cnt_ff <= W'(LEN_RST);
    else if (load)
      cnt_ff <= load_val;
    else if (tick && cnt_ff != '0)
      cnt_ff <= cnt_ff - W'(1);
  end

  // pulse once as the count steps from one to zero
  always_ff @(posedge mclk)
  begin
    if (rst)
      ufl_ff <= 1'b0;
    else
      ufl_ff <= !load && tick && cnt_ff == W'(1);
  end

  assign count   = cnt_ff;
  assign ufl_evt = ufl_ff;
endmodule : len_counter
`default_nettype wire

// >>> tb/ir_pulse_source.sv
`timescale 1ns/1ps
`default_nettype none
// far side of the unit: drives the receive data pulse and the counter clock enable
module ir_pulse_source
(
  input  wire logic mclk,      // system clock
  input  wire logic rst,       // sync reset, active high
  input  wire logic level_req, // level asked for on the data line
  input  wire logic tick_req,  // counter clock request
  output logic      data_in,   // data pulse to the unit
  output logic      len_tick   // count enable pulse to the unit
);
  // data line is registered so each change lands just after a rising edge
  always_ff @(posedge mclk)
  begin
    if (rst)
      data_in <= 1'b0;
    else
      data_in <= level_req;
  end
  // a pulse every other cycle while requested; a held request never gives two ticks in a row
  always_ff @(posedge mclk)
  begin
    if (rst)
      len_tick <= 1'b0;
    else
      len_tick <= tick_req && !len_tick;
  end
endmodule : ir_pulse_source
`default_nettype wire

// >>> tb/test_ir_remote_interrupt_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_ir_remote_interrupt_control
  import ir_irq_pkg::*;
;
  logic        mclk      = 1'b0;       // 100 MHz clock
  logic        rst       = 1'b1;       // sync reset
  logic [17:0] awaddr    = 18'h0_0000; // write address
  logic        awvalid   = 1'b0;       // write address valid
  logic [31:0] wdata     = 32'h0000_0000; // write data
  logic [3:0]  wstrb     = 4'h0;       // write strobes
  logic        wvalid    = 1'b0;       // write data valid
  logic        bready    = 1'b0;       // response ready
  logic [17:0] araddr    = 18'h0_0000; // read address
  logic        arvalid   = 1'b0;       // read address valid
  logic        rready    = 1'b0;       // read data ready
  logic        level_req = 1'b0;       // wanted data line level
  logic        tick_req  = 1'b0;       // counter tick request
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]  s_bresp, s_rresp;       // response codes
  logic [31:0] s_rdata, rd;            // read data, last read word
  logic        data_in, len_tick, irq_request;
  logic [31:0] seed      = 32'h0000_005D; // fixed seed
  logic [2:0]  exp_flg   = 3'h0;       // expected flags: fall, rise, underflow
  logic [2:0]  en        = 3'h0;       // enables last written
  logic        lvl       = 1'b0;       // data line level last asked for
  int          fails     = 0;          // mismatches
  int          num_checks = 0;         // comparisons

  always #5 mclk = ~mclk;

  `define CHK(got, want) begin num_checks++; if ((got) !== (want)) begin fails++; \
    $display("Error at %0t: got %h expected %h", $time, (got), (want)); end end

  ir_remote_interrupt_control ir_remote_interrupt_control_i (
    .mclk(mclk), .rst(rst), .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(s_awready),
    .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(bready), .s_araddr(araddr),
    .s_arvalid(arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(rready), .data_in(data_in), .len_tick(len_tick),
    .irq_request(irq_request));

  ir_pulse_source ir_pulse_source_i (
    .mclk(mclk), .rst(rst), .level_req(level_req), .tick_req(tick_req),
    .data_in(data_in), .len_tick(len_tick));

  // xorshift step for repeatable stimulus
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xs

  // expected image of the irq control register from flags and enables
  function automatic logic [31:0] ctrl_word(input logic [2:0] f, input logic [2:0] e);
    return {21'h00_0000, f, 5'h00, e};
  endfunction : ctrl_word

  // write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge mclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done)
    begin
      @(posedge mclk);
      if (awvalid && s_awready === 1'b1)
        awvalid <= 1'b0;
      if (wvalid && s_wready === 1'b1)
        wvalid <= 1'b0;
      if (s_bvalid === 1'b1)
      begin
        done = 1'b1;
        bready <= 1'b0;
        `CHK(s_bresp, er)
      end
    end
  endtask : axi_wr

  // read: data and response taken at the edge that shows rvalid
  task automatic axi_rd(input logic [17:0] a, output logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done)
    begin
      @(posedge mclk);
      if (arvalid && s_arready === 1'b1)
        arvalid <= 1'b0;
      if (s_rvalid === 1'b1)
      begin
        done = 1'b1;
        d = s_rdata;
        rready <= 1'b0;
        `CHK(s_rresp, er)
      end
    end
  endtask : axi_rd

  // level change, then time for the two-edge flag path to land
  task automatic set_level(input logic v);
    @(posedge mclk);
    level_req <= v;
    repeat (5) @(posedge mclk);
  endtask : set_level

  // one counter tick, then time for the underflow path
  task automatic tick;
    @(posedge mclk);
    tick_req <= 1'b1;
    @(posedge mclk);
    tick_req <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : tick

  task automatic finish_test;
    $display("Checks: %0d, mismatches: %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  // watchdog well above the several hundred cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge mclk);
    fails++;
    finish_test;
  end

  initial
  begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    axi_rd(IRQ_CTRL_ADDR, rd, RESP_OKAY);
    `CHK(rd, 32'h0000_0000)
    `CHK(irq_request, 1'b0)
    axi_rd(18'h0_0200, rd, RESP_SLVERR);
    `CHK(rd, 32'h0000_0000)
    // unmapped write answers an error and must touch nothing
    axi_wr(18'h0_0200, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
    axi_rd(IRQ_CTRL_ADDR, rd, RESP_OKAY);
    `CHK(rd, 32'h0000_0000)
    // all ones on lane 0: only the enables may stick
    axi_wr(IRQ_CTRL_ADDR, 32'hFFFF_FFFF, 4'h1, RESP_OKAY);
    axi_rd(IRQ_CTRL_ADDR, rd, RESP_OKAY);
    `CHK(rd, 32'h0000_0007)
    axi_wr(IRQ_CTRL_ADDR, 32'h0000_0000, 4'h1, RESP_OKAY);
    // transmit direction: edges must not count
    set_level(1'b1);
    set_level(1'b0);
    axi_rd(IRQ_CTRL_ADDR, rd, RESP_OKAY);
    `CHK(rd, 32'h0000_0000)
    axi_wr(UNIT_CFG_ADDR, 32'h0000_0001, 4'h1, RESP_OKAY);
    set_level(1'b1);
    axi_rd(IRQ_CTRL_ADDR, rd, RESP_OKAY);
    `CHK(rd, 32'h0000_0200)
    `CHK(irq_request, 1'b0)
    set_level(1'b0);
    axi_rd(IRQ_CTRL_ADDR, rd, RESP_OKAY);
    `CHK(rd, 32'h0000_0600)
    axi_wr(IRQ_CTRL_ADDR, 32'h0000_0000, 4'h2, RESP_OKAY);
    axi_rd(IRQ_CTRL_ADDR, rd, RESP_OKAY);
    `CHK(rd, 32'h0000_0600)
    axi_wr(IRQ_CTRL_ADDR, 32'h0000_0200, 4'h2, RESP_OKAY);
    axi_rd(IRQ_CTRL_ADDR, rd, RESP_OKAY);
    `CHK(rd, 32'h0000_0400)
    axi_wr(IRQ_CTRL_ADDR, 32'h0000_0004, 4'h1, RESP_OKAY);
    `CHK(irq_request, 1'b1)
    axi_wr(IRQ_CTRL_ADDR, 32'h0000_0400, 4'h2, RESP_OKAY);
    `CHK(irq_request, 1'b0)
    // length 3: underflow only on the third tick
    axi_wr(UNIT_CFG_ADDR, 32'h0000_0301, 4'h3, RESP_OKAY);
    tick;
    tick;
    axi_rd(IRQ_CTRL_ADDR, rd, RESP_OKAY);
    `CHK(rd, 32'h0000_0004)
    tick;
    axi_rd(IRQ_CTRL_ADDR, rd, RESP_OKAY);
    `CHK(rd, 32'h0000_0104)
    `CHK(irq_request, 1'b0)
    tick;
    axi_rd(UNIT_CFG_ADDR, rd, RESP_OKAY);
    `CHK(rd[15:8], 8'h00)
    axi_wr(IRQ_CTRL_ADDR, 32'h0000_0007, 4'h1, RESP_OKAY);
    `CHK(irq_request, 1'b1)
    axi_wr(IRQ_CTRL_ADDR, 32'h0000_0100, 4'h2, RESP_OKAY);
    `CHK(irq_request, 1'b0)
    // random events, enables and clears against a running flag model
    for (int i = 0; i < 24; i++)
    begin
      seed = xs(seed);
      if (seed[0])
      begin
        lvl = ~lvl;
        set_level(lvl);
        exp_flg = exp_flg | (lvl ? 3'b010 : 3'b100);
      end
      if (seed[1])
      begin
        axi_wr(UNIT_CFG_ADDR, 32'h0000_0101, 4'h3, RESP_OKAY);
        tick;
        exp_flg = exp_flg | 3'b001;
      end
      en = seed[4:2];
      axi_wr(IRQ_CTRL_ADDR, {29'h0, en}, 4'h1, RESP_OKAY);
      axi_rd(IRQ_CTRL_ADDR, rd, RESP_OKAY);
      `CHK(rd, ctrl_word(exp_flg, en))
      `CHK(irq_request, |(exp_flg & en))
      axi_wr(IRQ_CTRL_ADDR, {21'h0, seed[7:5], 8'h00}, 4'h2, RESP_OKAY);
      exp_flg = exp_flg & ~seed[7:5];
    end
    // reset in mid-run must drop flags, enables and the request
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    axi_rd(IRQ_CTRL_ADDR, rd, RESP_OKAY);
    `CHK(rd, 32'h0000_0000)
    `CHK(irq_request, 1'b0)
    finish_test;
  end
endmodule : test_ir_remote_interrupt_control
`default_nettype wire
